// ### logic/pwc_pkg.sv
// Package with register map, field layout, timing constants and carrier types.
package pwc_pkg;

  localparam int          APB_AW          = 8;
  localparam int          APB_DW          = 32;

  // Register byte offsets.
  localparam logic [7:0]  OFS_WAKE_CTRL   = 8'h84;
  localparam logic [7:0]  OFS_ENDIAN_TEST = 8'h64;

  // Field positions of the power_wake_control register.
  localparam int          BIT_READY       = 0;
  localparam int          BIT_PIN_EN      = 1;
  localparam int          BIT_POLARITY    = 2;
  localparam int          BIT_PULSE_SEL   = 3;
  localparam int          BIT_CAUSE_LO    = 4;
  localparam int          BIT_CAUSE_HI    = 5;
  localparam int          BIT_DRIVE_TYPE  = 6;
  localparam int          BIT_ENERGY_WAKE_ENABLE       = 8;
  localparam int          BIT_WF_EN       = 9;
  localparam int          BIT_XCVR_RST    = 10;
  localparam int          BIT_PS_LO       = 12;
  localparam int          BIT_PS_HI       = 13;

  // Value read back from the endian test register; the pattern is arbitrary.
  localparam logic [31:0] ENDIAN_PATTERN  = 32'h0A5A_5A0F;

  // Timing, each in its own unit, and derived cycle counts.
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          XCVR_RST_MIN_US = 100;
  localparam int          PULSE_MS        = 50;
  localparam int          SETTLE_NS       = 2000;
  // A least time rounds up to whole cycles.
  localparam int          XCVR_RST_CYC    = (XCVR_RST_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int          PULSE_CYC       = (PULSE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0]  CAUSE_NONE      = 2'h0;

  typedef enum logic [1:0] {
    PS_FULL   = 2'h0,
    PS_WAKE   = 2'h1,
    PS_ENERGY = 2'h2
  } pwc_pstate_t;

  typedef struct packed {
    logic wf_en;
    logic energy_wake_enable;
    logic drive_type;
    logic pulse_sel;
    logic polarity;
    logic pin_en;
  } pwc_ctrl_t;

  localparam pwc_ctrl_t   CTRL_RESET      = '{default: 1'b0};

endpackage

// ### logic/pwc_timer.sv
// Down-counting hold timer that reports busy while the loaded time runs.
`timescale 1ns/10ps
module pwc_timer
  import pwc_pkg::*;
#(
  parameter int CNT_W  = 12,
  parameter int CYCLES = 16
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      busy_o
);

  generate
    if (CYCLES < 1 || CYCLES >= (2 ** CNT_W)) begin : g_chk
      $error("pwc_timer: CYCLES does not fit CNT_W");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      busy_o  <= 1'b0;
    end else if (stop_i) begin
      cnt_reg <= '0;
      busy_o  <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= LOAD;
      busy_o  <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - ONE;
      busy_o  <= (cnt_reg != ONE);
    end
  end

endmodule

// ### logic/pwc_cause_bit.sv
// One sticky wake cause bit with write-one-to-clear held off by a live source.
`timescale 1ns/10ps
module pwc_cause_bit (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic src_i,
  input  wire logic clr_i,
  output logic      flag_o,
  output logic      rise_o
);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      // A live source both sets the bit and blocks the clear, so set wins.
      flag_o <= src_i | (flag_o & ~clr_i);
      rise_o <= src_i & ~flag_o;
    end
  end

endmodule

// ### logic/pwc_wake_ctrl.sv
// Power state, transceiver reset, wake cause and wake pin control behind APB.
// Operation
// - Control register readable in every power state.
// - Bits 13-12 select power state, self-clearing.
// - Endian test write wakes from reduced state.
// - Bit 10 resets transceiver at least 100us.
// - Reset bit writes ignored while it reads high.
// - Wake frame event raises interrupt and pin.
// - Energy event raises interrupt and pin.
// - Bit 6 picks open-drain or push-pull pin.
// - Bit 2 sets push-pull pin polarity.
// - Bits 5-4 report the wake cause.
// - Cause cleared by one, only when fully ready.
// - Cause clears only after its source clears.
// - Bit 3 picks 50ms pulse or static pin.
// - Pin drops on cause or enable clear.
// - Bit 1 gates pin, never the interrupt.
// - Bit 0 reads one once device stabilised.
`timescale 1ns/10ps
module pwc_wake_ctrl
  import pwc_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int PULSE_W      = 21
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [APB_DW-1:0] pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              wake_frame_src_i,
  input  wire logic              energy_src_i,
  output logic      [1:0]        power_state_o,
  output logic                   xcvr_rst_o,
  output logic                   wake_interrupt_o,
  output logic                   wake_pin_o,
  output logic                   wake_pin_oe_o
);

  pwc_pstate_t  ps_reg;
  pwc_ctrl_t    ctrl_reg;
  logic         ready_reg;
  logic         read_seen_reg;
  logic         boot_reg;
  logic         settle_busy;
  logic         pulse_busy;
  logic [1:0]   cause;
  logic [1:0]   cause_rise;
  logic         setup;
  logic         access;
  logic         hit_ctrl;
  logic         hit_endian;
  logic         wr_ok;
  logic         wr_ctrl;
  logic         wr_endian;
  logic         reduced;
  logic         wake_go;
  logic         sleep_go;
  logic         settle_start;
  logic         xcvr_start;
  logic [1:0]   ps_wr;
  logic [1:0]   cause_clr;
  logic         wf_src;
  logic         ed_src;
  logic         want_pin;
  logic         pin_active;
  logic [31:0]  ctrl_view;

  // The reset and settle counters are sized from their own counts, so a changed time cannot overflow them.
  localparam int XCVR_CNT_W   = $clog2(XCVR_RST_CYC + 1);
  localparam int SETTLE_CNT_W = $clog2(SETTLE_CYC + 1);

  // The pulse counter must hold the whole pulse, or the pin would drop early.
  generate
    if (PULSE_W < 1 || PULSE_W > 30) begin : g_chk_width
      $error("pwc_wake_ctrl: PULSE_W out of range");
    end
    if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (2 ** PULSE_W)) begin : g_chk_pulse
      $error("pwc_wake_ctrl: PULSE_CYCLES does not fit PULSE_W");
    end
  endgenerate

  // Only whole-word writes are taken; a partial strobe could tear the self-clearing fields.
  assign setup      = psel_i & ~penable_i;
  assign access     = psel_i & penable_i & pready_o;
  assign hit_ctrl   = (paddr_i == OFS_WAKE_CTRL);
  assign hit_endian = (paddr_i == OFS_ENDIAN_TEST);
  assign wr_ok      = access & pwrite_i & read_seen_reg & (pstrb_i == 4'hF);
  assign wr_ctrl    = wr_ok & hit_ctrl;
  assign wr_endian  = wr_ok & hit_endian;
  assign reduced    = (ps_reg != PS_FULL);
  assign ps_wr      = pwdata_i[BIT_PS_HI:BIT_PS_LO];

  assign wf_src = ctrl_reg.wf_en & wake_frame_src_i;
  assign ed_src = ctrl_reg.energy_wake_enable & energy_src_i;

  // An enabled event also ends a reduced state, as does a write to the endian test word.
  assign wake_go  = reduced & (wr_endian | wf_src | ed_src);
  assign sleep_go = wr_ctrl & ~reduced & ready_reg
                  & ((ps_wr == PS_WAKE) | (ps_wr == PS_ENERGY));
  assign settle_start = ~boot_reg | wake_go;
  assign xcvr_start   = wr_ctrl & pwdata_i[BIT_XCVR_RST] & ~xcvr_rst_o;

  // Clear strobe only counts in full power with ready set; live sources hold the bit.
  assign cause_clr[0] = wr_ctrl & ~reduced & ready_reg & pwdata_i[BIT_CAUSE_LO];
  assign cause_clr[1] = wr_ctrl & ~reduced & ready_reg & pwdata_i[BIT_CAUSE_HI];

  pwc_cause_bit u_cause_energy (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (ed_src),
    .clr_i     (cause_clr[0]),
    .flag_o    (cause[0]),
    .rise_o    (cause_rise[0])
  );

  pwc_cause_bit u_cause_frame (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (wf_src),
    .clr_i     (cause_clr[1]),
    .flag_o    (cause[1]),
    .rise_o    (cause_rise[1])
  );

  pwc_timer #(
    .CNT_W  (XCVR_CNT_W),
    .CYCLES (XCVR_RST_CYC)
  ) u_xcvr_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (xcvr_start),
    .stop_i    (1'b0),
    .busy_o    (xcvr_rst_o)
  );

  pwc_timer #(
    .CNT_W  (SETTLE_CNT_W),
    .CYCLES (SETTLE_CYC)
  ) u_settle_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (settle_start),
    .stop_i    (1'b0),
    .busy_o    (settle_busy)
  );

  // A fresh event restarts the pulse; losing cause or enable ends it early.
  pwc_timer #(
    .CNT_W  (PULSE_W),
    .CYCLES (PULSE_CYCLES)
  ) u_pulse_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (|cause_rise),
    .stop_i    (~want_pin),
    .busy_o    (pulse_busy)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boot_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ps_reg <= PS_FULL;
    end else if (wake_go) begin
      ps_reg <= PS_FULL;
    end else if (sleep_go) begin
      ps_reg <= pwc_pstate_t'(ps_wr);
    end
  end

  // Ready stays low through the settle time after reset and after every wake.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_reg <= 1'b0;
    end else if (sleep_go | settle_start) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ~reduced & ~settle_busy;
    end
  end

  // Writes stay dead until the host has completed a read since reset, sleep or wake.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      read_seen_reg <= 1'b0;
    end else if (sleep_go | wake_go) begin
      read_seen_reg <= 1'b0;
    end else if (access & ~pwrite_i) begin
      read_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg.wf_en      <= pwdata_i[BIT_WF_EN];
      ctrl_reg.energy_wake_enable      <= pwdata_i[BIT_ENERGY_WAKE_ENABLE];
      ctrl_reg.drive_type <= pwdata_i[BIT_DRIVE_TYPE];
      ctrl_reg.pulse_sel  <= pwdata_i[BIT_PULSE_SEL];
      ctrl_reg.polarity   <= pwdata_i[BIT_POLARITY];
      ctrl_reg.pin_en     <= pwdata_i[BIT_PIN_EN];
    end
  end

  // Interrupt follows cause and enable only; the pin enable has no say here.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_interrupt_o <= 1'b0;
    end else begin
      wake_interrupt_o <= (cause[1] & ctrl_reg.wf_en)
                        | (cause[0] & ctrl_reg.energy_wake_enable);
    end
  end

  assign want_pin   = ctrl_reg.pin_en & ((cause[1] & ctrl_reg.wf_en)
                    | (cause[0] & ctrl_reg.energy_wake_enable));
  assign pin_active = want_pin & (~ctrl_reg.pulse_sel | pulse_busy);

  // Open drain pulls low only while active; push-pull drives always with chosen polarity.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_pin_o    <= 1'b0;
      wake_pin_oe_o <= 1'b0;
    end else if (ctrl_reg.drive_type) begin
      wake_pin_o    <= ~(pin_active ^ ctrl_reg.polarity);
      wake_pin_oe_o <= 1'b1;
    end else begin
      wake_pin_o    <= 1'b0;
      wake_pin_oe_o <= pin_active;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_state_o <= PS_FULL;
    end else begin
      power_state_o <= ps_reg;
    end
  end

  always_comb begin
    ctrl_view                            = '0;
    ctrl_view[BIT_PS_HI:BIT_PS_LO]       = ps_reg;
    ctrl_view[BIT_XCVR_RST]              = xcvr_rst_o;
    ctrl_view[BIT_WF_EN]                 = ctrl_reg.wf_en;
    ctrl_view[BIT_ENERGY_WAKE_ENABLE]                 = ctrl_reg.energy_wake_enable;
    ctrl_view[BIT_DRIVE_TYPE]            = ctrl_reg.drive_type;
    ctrl_view[BIT_CAUSE_HI:BIT_CAUSE_LO] = cause;
    ctrl_view[BIT_PULSE_SEL]             = ctrl_reg.pulse_sel;
    ctrl_view[BIT_POLARITY]              = ctrl_reg.polarity;
    ctrl_view[BIT_PIN_EN]                = ctrl_reg.pin_en;
    ctrl_view[BIT_READY]                 = ready_reg;
  end

  // No wait state: the answer is formed in the setup cycle and stands for the access cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (setup) begin
      pready_o  <= 1'b1;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
      if (hit_ctrl) begin
        if (!pwrite_i) begin
          prdata_o <= ctrl_view;
        end
      end else if (hit_endian) begin
        if (!pwrite_i) begin
          prdata_o  <= ready_reg ? ENDIAN_PATTERN : '0;
          pslverr_o <= ~ready_reg;
        end
      end else begin
        pslverr_o <= 1'b1;
      end
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end
  end

endmodule

// ### verification/pwc_wake_ctrl_asserts.sv
// Concurrent checks on the ports of the power and wake control block.
`timescale 1ns/10ps
module pwc_wake_ctrl_asserts
  import pwc_pkg::*;
#(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        wake_frame_src_i,
  input wire logic        energy_src_i,
  input wire logic [1:0]  power_state_o,
  input wire logic        xcvr_rst_o,
  input wire logic        wake_interrupt_o,
  input wire logic        wake_pin_o,
  input wire logic        wake_pin_oe_o
);
  logic wr_s;
  logic wr_rst;
  logic src_any;
  int   hi_cnt;
  assign wr_s    = psel_i && penable_i && pwrite_i;
  assign wr_rst  = wr_s && pwdata_i[BIT_XCVR_RST];
  assign src_any = wake_frame_src_i || energy_src_i;
  // Counts how long the transceiver reset has been held so far.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !xcvr_rst_o) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_pready_single: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_pready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_xrst_hold_min: assert property ($fell(xcvr_rst_o) |-> hi_cnt >= XCVR_RST_CYC)
    else $error("transceiver reset too short");
  a_xrst_self_clear: assert property (xcvr_rst_o |-> hi_cnt <= XCVR_RST_CYC + 8)
    else $error("transceiver reset never clears");
  a_xrst_by_write: assert property ($rose(xcvr_rst_o) |-> $past(wr_rst) || $past(wr_rst, 2))
    else $error("transceiver reset without write");
  a_int_by_event: assert property ($rose(wake_interrupt_o) |->
    $past(src_any) || $past(src_any, 2) || $past(src_any, 3))
    else $error("interrupt without event");
  a_od_low_only: assert property (!wake_pin_oe_o |-> !wake_pin_o)
    else $error("open drain pin drives high");
  a_state_by_write: assert property ($changed(power_state_o) && power_state_o != 2'h0
    |-> $past(wr_s) || $past(wr_s, 2))
    else $error("power state entered without write");
  a_wake_cause: assert property ($changed(power_state_o) && power_state_o == 2'h0
    |-> $past(wr_s) || $past(wr_s, 2) || $past(src_any) || $past(src_any, 2))
    else $error("wake without write or event");
endmodule

bind pwc_wake_ctrl pwc_wake_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .wake_frame_src_i(wake_frame_src_i), .energy_src_i(energy_src_i),
  .power_state_o(power_state_o), .xcvr_rst_o(xcvr_rst_o),
  .wake_interrupt_o(wake_interrupt_o), .wake_pin_o(wake_pin_o), .wake_pin_oe_o(wake_pin_oe_o));

// ### verification/pwc_evt_src.sv
// Event source model standing in for the wake frame and energy detectors.
`timescale 1ns/10ps
module pwc_evt_src (
  input  wire logic clk_i,
  input  wire logic wf_req_i,
  input  wire logic ed_req_i,
  output logic      wf_src_o,
  output logic      ed_src_o
);
  // Registered so the sources move just after an edge, as same-clock detectors would.
  always_ff @(posedge clk_i) begin
    wf_src_o <= wf_req_i;
    ed_src_o <= ed_req_i;
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the power and wake control block.
`timescale 1ns/10ps
module tb_top;
  import pwc_pkg::*;
  localparam int PC = 20;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic        wf_req    = 1'b0;
  logic        ed_req    = 1'b0;
  logic [31:0] prdata_o;
  logic [31:0] rq;
  logic [31:0] cfg;
  logic [1:0]  power_state_o;
  logic        pready_o, pslverr_o, re, wf_src, ed_src;
  logic        xcvr_rst_o, wake_interrupt_o, wake_pin_o, wake_pin_oe_o;
  int          errors = 0;
  int          checks = 0;
  int          seed   = 5292;
  int          n;
  always #25 clk_i = ~clk_i;
  pwc_wake_ctrl #(.PULSE_CYCLES(PC)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .wake_frame_src_i(wf_src), .energy_src_i(ed_src), .power_state_o(power_state_o),
    .xcvr_rst_o(xcvr_rst_o), .wake_interrupt_o(wake_interrupt_o),
    .wake_pin_o(wake_pin_o), .wake_pin_oe_o(wake_pin_oe_o));
  pwc_evt_src u_src (
    .clk_i(clk_i), .wf_req_i(wf_req), .ed_req_i(ed_req), .wf_src_o(wf_src), .ed_src_o(ed_src));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) errors++;
    rq = prdata_o;
    re = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_rdy();
    rq = 32'h0000_0000;
    for (int i = 0; i < 80 && rq[0] !== 1'b1; i++) apb(1'b0, OFS_WAKE_CTRL, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // A write before any read must be dropped; only this register is written.
    apb(1'b1, OFS_WAKE_CTRL, 32'h0000_034E);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, 32'h0000_0000);
    apb(1'b0, OFS_ENDIAN_TEST, 32'h0);
    chk(re, 1'b1);
    wait_rdy();
    chk(rq, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0);
    chk(re, 1'b1);
    repeat (4) begin
      cfg = $random(seed) & 32'h0000_034E;
      apb(1'b1, OFS_WAKE_CTRL, cfg);
      apb(1'b0, OFS_WAKE_CTRL, 32'h0);
      chk(rq, cfg | 32'h1);
      chk({wake_pin_oe_o, wake_pin_o}, cfg[6] ? {1'b1, ~cfg[2]} : 2'b00);
    end
    apb(1'b1, OFS_WAKE_CTRL, cfg | 32'h400);
    apb(1'b1, OFS_WAKE_CTRL, cfg);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h401);
    n = 0;
    while (xcvr_rst_o === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= XCVR_RST_CYC - 12 && n < XCVR_RST_CYC, 1'b1);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h1);
    // Static push-pull active-high pin; sleep codes are never the reserved one.
    cfg = 32'h0000_0246;
    apb(1'b1, OFS_WAKE_CTRL, cfg);
    apb(1'b1, OFS_WAKE_CTRL, cfg | 32'h1000);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h1000);
    wf_req <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({wake_interrupt_o, wake_pin_oe_o, wake_pin_o, power_state_o}, 5'h1C);
    wait_rdy();
    chk(rq, cfg | 32'h21);
    apb(1'b1, OFS_WAKE_CTRL, cfg | 32'h20);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h21);
    wf_req <= 1'b0;
    apb(1'b1, OFS_WAKE_CTRL, cfg | 32'h20);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h1);
    chk({wake_interrupt_o, wake_pin_oe_o, wake_pin_o}, 3'b010);
    // Energy event with the pin gated off, then a pulsed open-drain pin.
    cfg = 32'h0000_0108;
    apb(1'b1, OFS_WAKE_CTRL, cfg);
    ed_req <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({wake_interrupt_o, wake_pin_oe_o}, 2'b10);
    ed_req <= 1'b0;
    apb(1'b1, OFS_WAKE_CTRL, cfg | 32'h12);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h3);
    ed_req <= 1'b1;
    @(posedge clk_i);
    ed_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({wake_pin_oe_o, wake_pin_o}, 2'b10);
    repeat (PC - 1) @(posedge clk_i);
    chk(wake_pin_oe_o, 1'b1);
    @(posedge clk_i);
    chk({wake_interrupt_o, wake_pin_oe_o}, 2'b10);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(rq, cfg | 32'h13);
    apb(1'b1, OFS_WAKE_CTRL, 32'h2000);
    apb(1'b0, OFS_WAKE_CTRL, 32'h0);
    chk(power_state_o, 2'h2);
    // Only the wake-up write goes out while the device is not ready.
    apb(1'b1, OFS_ENDIAN_TEST, $random(seed));
    repeat (2) @(posedge clk_i);
    chk(power_state_o, 2'h0);
    wait_rdy();
    chk(rq, 32'h0000_0011);
    finish_test();
  end
  initial begin
    #(20000 * 50);
    errors++;
    finish_test();
  end
endmodule
